// ### hdl/sdf_pkg.sv
// ==========================================================================
// Shared constants and carriers
package sdf_pkg;
  // ========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_DI_MAP_LO = 8'h00;
  localparam logic [7:0] OFS_DI_MAP_HI = 8'h04;
  localparam logic [7:0] OFS_DO_MAP = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_ZERO_THR = 8'h10;
  localparam logic [7:0] OFS_TARGET_THR = 8'h14;
  localparam logic [7:0] OFS_POS_WIN = 8'h18;
  localparam logic [7:0] OFS_GEAR_NUM1 = 8'h1c;
  localparam logic [7:0] OFS_GEAR_DEN = 8'h2c;
  localparam logic [7:0] OFS_TQ_CFG = 8'h30;
  localparam logic [7:0] OFS_BRK_ON = 8'h34;
  localparam logic [7:0] OFS_BRK_OFF = 8'h38;
  localparam logic [7:0] OFS_LIVE = 8'h3c;
  localparam logic [7:0] OFS_INT_STAT = 8'h40;
  localparam logic [7:0] OFS_INT_MASK = 8'h44;
  // ========================================================================
  // Input function codes
  localparam logic [7:0] FN_JOG_FWD = 8'h37;
  localparam logic [7:0] FN_JOG_REV = 8'h38;
  localparam logic [7:0] FN_GEAR_B0 = 8'h43;
  localparam logic [7:0] FN_GEAR_B1 = 8'h44;
  localparam logic [7:0] FN_PULSE_INH = 8'h45;
  localparam logic [7:0] FN_TQ_POS = 8'h48;
  localparam logic [7:0] FN_TQ_NEG = 8'h49;
  localparam logic [7:0] FN_SEL_PT_S = 8'h18;
  localparam logic [7:0] FN_SEL_S_T = 8'h19;
  localparam logic [7:0] FN_SEL_T_PT = 8'h20;
  // Output function codes 0x01..0x08 index the function vector
  localparam int FN_DO_MAX = 8;
  // ========================================================================
  // Control mode setting values
  localparam logic [7:0] MODE_PT = 8'd11;
  localparam logic [7:0] MODE_S = 8'd12;
  localparam logic [7:0] MODE_T = 8'd13;
  localparam logic [7:0] MODE_SZ = 8'd14;
  localparam logic [7:0] MODE_TZ = 8'd15;
  localparam logic [7:0] MODE_SINGLE_HI = 8'd17;
  localparam logic [7:0] MODE_PT_S = 8'd18;
  localparam logic [7:0] MODE_S_T = 8'd19;
  localparam logic [7:0] MODE_PT_T = 8'd20;
  // ========================================================================
  // Reset values and timing
  localparam logic [7:0] RST_MODE = MODE_PT;
  localparam logic [15:0] RST_ZERO_THR = 16'h000a;
  localparam logic [15:0] RST_TARGET_THR = 16'h0bb8;
  localparam logic [15:0] RST_POS_WIN = 16'h0064;
  localparam logic [31:0] RST_GEAR = 32'h0000_0001;
  localparam int CLK_HZ = 100_000_000;
  localparam int BRK_UNIT_US = 1000;
  localparam int MS_CYCLES = CLK_HZ / 1_000_000 * BRK_UNIT_US;
  localparam int INT_BITS = 4;
  // ========================================================================
  typedef enum logic [2:0] {MD_PT, MD_S, MD_T, MD_SZ, MD_TZ} sdf_mode_e;
  typedef struct packed {
    logic ctrl_pwr;
    logic main_pwr;
    logic servo_en;
    logic alm_general;
    logic alm_limit;
    logic alm_comm;
    logic alm_uvolt;
    logic torque_limit;
    logic brake_cmd;
  } sdf_drv_s;
  typedef struct packed {
    logic jog_fwd;
    logic jog_rev;
    logic pulse_en;
    logic [1:0] gear_sel;
    logic [1:0] tq_src;
    logic tq_neg;
    sdf_mode_e mode;
  } sdf_cmd_s;
endpackage

// ### hdl/sdf_dio_map.sv
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
// Functional notes
// R1: Forward-jog input held active jogs the motor forward, any mode.
// R2: Reverse-jog input held active jogs the motor in reverse, any mode.
// R3: In position mode two gear inputs pick one of four numerators.
// R4: In position mode pulse-inhibit input blocks the external pulse command.
// R5: In torque mode two inputs pick torque source, meaning set by config bit 0.
// R6: Mode values 11-17 are single modes, 18-20 switch between two modes.
// R7: An input mapped to code zero does nothing.
// R8: Ready output is on with control and main power and no alarm.
// R9: Servo-on output is on while enabled and no alarm.
// R10: Zero-speed output is on while speed is below its threshold.
// R11: Target-speed output is on while speed exceeds its threshold.
// R12: In position mode in-position is on while error is below the window.
// R13: Torque-limit output shows limiting, except in torque modes.
// R14: Fault output shows alarms except limit, communication and undervoltage.
// R15: Brake-release output follows brake command with two delays.
// R16: All mapped functions are levels sampled every cycle.
module sdf_dio_map #(
  parameter int N_DI = 8,
  parameter int N_DO = 4,
  parameter int MS_CYC = sdf_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Pins
  input wire logic [N_DI-1:0] DI_PIN,
  output logic [N_DO-1:0] DO_PIN,
  // Drive core
  input wire sdf_pkg::sdf_drv_s DRV,
  input wire logic [15:0] SPEED,
  input wire logic [15:0] POS_ERR,
  output sdf_pkg::sdf_cmd_s CMD,
  output logic [31:0] GEAR_NUM,
  output logic [31:0] GEAR_DEN,
  output logic IRQ
);
  import sdf_pkg::*;

  if (N_DI < 1 || N_DI > 8)
  begin : g_chk_di
    $error("N_DI must be 1..8");
  end
  if (N_DO < 1 || N_DO > 4)
  begin : g_chk_do
    $error("N_DO must be 1..4");
  end
  if (MS_CYC < 1)
  begin : g_chk_ms
    $error("MS_CYC must be at least 1");
  end

  // ========================================================================
  // Helpers
  function automatic logic [15:0] mag(input logic [15:0] v);
    return v[15] ? 16'(~v + 16'h0001) : v;
  endfunction

  function automatic logic di_fn(input logic [7:0] code, input logic [63:0] map,
                                 input logic [7:0] lvl);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_DI; i++)
    begin
      if (map[i*8 +: 8] == code && code != 8'h00)
        hit = hit | lvl[i];
    end
    return hit;
  endfunction

  // ========================================================================
  // Registers
  logic [63:0] di_map_q;
  logic [31:0] do_map_q;
  logic [7:0] mode_q;
  logic [15:0] zero_thr_q, target_thr_q, pos_win_q, brk_on_q, brk_off_q;
  logic [31:0] gear_q [4];
  logic [31:0] gear_den_q;
  logic tq_cfg_q;
  logic [INT_BITS-1:0] int_stat_q, int_mask_q, int_ev;
  logic [31:0] rdata_q;

  wire wr_di_lo = WR && ADDR == OFS_DI_MAP_LO;
  wire wr_di_hi = WR && ADDR == OFS_DI_MAP_HI;
  wire wr_int = WR && ADDR == OFS_INT_STAT;
  wire [INT_BITS-1:0] int_clr = wr_int ? WDATA[INT_BITS-1:0] : '0;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      di_map_q <= '0;
      do_map_q <= '0;
      mode_q <= RST_MODE;
      zero_thr_q <= RST_ZERO_THR;
      target_thr_q <= RST_TARGET_THR;
      pos_win_q <= RST_POS_WIN;
      gear_q <= '{default: RST_GEAR};
      gear_den_q <= RST_GEAR;
      tq_cfg_q <= 1'b0;
      brk_on_q <= '0;
      brk_off_q <= '0;
      int_mask_q <= '0;
    end
    else if (WR)
    begin
      if (wr_di_lo)
        di_map_q[31:0] <= WDATA;
      if (wr_di_hi)
        di_map_q[63:32] <= WDATA;
      case (ADDR)
        OFS_DO_MAP: do_map_q <= WDATA;
        OFS_MODE: mode_q <= WDATA[7:0];
        OFS_ZERO_THR: zero_thr_q <= WDATA[15:0];
        OFS_TARGET_THR: target_thr_q <= WDATA[15:0];
        OFS_POS_WIN: pos_win_q <= WDATA[15:0];
        OFS_GEAR_NUM1: gear_q[0] <= WDATA;
        OFS_GEAR_NUM1 + 8'h04: gear_q[1] <= WDATA;
        OFS_GEAR_NUM1 + 8'h08: gear_q[2] <= WDATA;
        OFS_GEAR_NUM1 + 8'h0c: gear_q[3] <= WDATA;
        OFS_GEAR_DEN: gear_den_q <= WDATA;
        OFS_TQ_CFG: tq_cfg_q <= WDATA[0];
        OFS_BRK_ON: brk_on_q <= WDATA[15:0];
        OFS_BRK_OFF: brk_off_q <= WDATA[15:0];
        OFS_INT_MASK: int_mask_q <= WDATA[INT_BITS-1:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Input pins: three stages, a change counts once stages two and three agree
  logic [N_DI-1:0] di_s1_q, di_s2_q, di_s3_q, di_q;
  wire [N_DI-1:0] di_agree = ~(di_s2_q ^ di_s3_q);
  wire [N_DI-1:0] di_d = (di_agree & di_s3_q) | (~di_agree & di_q);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      di_s1_q <= '0;
      di_s2_q <= '0;
      di_s3_q <= '0;
      di_q <= '0;
    end
    else
    begin
      di_s1_q <= DI_PIN;
      di_s2_q <= di_s1_q;
      di_s3_q <= di_s2_q;
      di_q <= di_d; // [R16]
    end
  end

  wire [7:0] di_lvl = 8'(di_q);
  // Zero codes never match, so unmapped pins are inert [R7]
  wire in_jog_f = di_fn(FN_JOG_FWD, di_map_q, di_lvl);
  wire in_jog_r = di_fn(FN_JOG_REV, di_map_q, di_lvl);
  wire in_g0 = di_fn(FN_GEAR_B0, di_map_q, di_lvl);
  wire in_g1 = di_fn(FN_GEAR_B1, di_map_q, di_lvl);
  wire in_inh = di_fn(FN_PULSE_INH, di_map_q, di_lvl);
  wire in_tqp = di_fn(FN_TQ_POS, di_map_q, di_lvl);
  wire in_tqn = di_fn(FN_TQ_NEG, di_map_q, di_lvl);
  wire in_pt_s = di_fn(FN_SEL_PT_S, di_map_q, di_lvl);
  wire in_s_t = di_fn(FN_SEL_S_T, di_map_q, di_lvl);
  wire in_t_pt = di_fn(FN_SEL_T_PT, di_map_q, di_lvl);

  // ========================================================================
  // Effective control mode; unknown settings fall back to position mode
  sdf_mode_e mode_eff;
  always_comb
  begin
    case (mode_q) // [R6]
      MODE_S: mode_eff = MD_S;
      MODE_T: mode_eff = MD_T;
      MODE_SZ: mode_eff = MD_SZ;
      MODE_TZ: mode_eff = MD_TZ;
      MODE_PT_S: mode_eff = in_pt_s ? MD_PT : MD_S;
      MODE_S_T: mode_eff = in_s_t ? MD_T : MD_S;
      MODE_PT_T: mode_eff = in_t_pt ? MD_PT : MD_T;
      default: mode_eff = MD_PT;
    endcase
  end

  wire is_pt = mode_eff == MD_PT;
  wire is_tq = mode_eff == MD_T || mode_eff == MD_TZ;

  // ========================================================================
  // Command outputs
  sdf_cmd_s cmd_d;
  // Both jog inputs at once cancel rather than pick a winner
  assign cmd_d.jog_fwd = in_jog_f && !in_jog_r; // [R1]
  assign cmd_d.jog_rev = in_jog_r && !in_jog_f; // [R2]
  assign cmd_d.gear_sel = is_pt ? {in_g1, in_g0} : 2'b00; // [R3]
  assign cmd_d.pulse_en = is_pt && !in_inh; // [R4]
  // Config bit 0 clear: inputs index the source; set: analog with sign
  assign cmd_d.tq_src = !is_tq ? 2'b00 : tq_cfg_q ? 2'b00 : {in_tqn, in_tqp}; // [R5]
  assign cmd_d.tq_neg = is_tq && tq_cfg_q && in_tqn && !in_tqp; // [R5]
  assign cmd_d.mode = mode_eff;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CMD <= '0;
      GEAR_NUM <= RST_GEAR;
      GEAR_DEN <= RST_GEAR;
    end
    else
    begin
      CMD <= cmd_d;
      GEAR_NUM <= gear_q[cmd_d.gear_sel]; // [R3]
      GEAR_DEN <= gear_den_q;
    end
  end

  // ========================================================================
  // Brake release timing in millisecond steps
  typedef enum logic [1:0] {BK_HELD, BK_REL_WAIT, BK_RELEASED, BK_HOLD_WAIT} sdf_brk_e;
  sdf_brk_e brk_q;
  logic [$clog2(MS_CYC+1)-1:0] pre_q;
  logic [15:0] ms_q;
  wire ms_tick = pre_q == ($bits(pre_q))'(MS_CYC - 1);
  wire brk_busy = brk_q == BK_REL_WAIT || brk_q == BK_HOLD_WAIT;
  wire rel_done = ms_q >= brk_on_q;
  wire hold_done = ms_q >= brk_off_q;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      brk_q <= BK_HELD;
      pre_q <= '0;
      ms_q <= '0;
    end
    else
    begin
      pre_q <= (!brk_busy || ms_tick) ? '0 : pre_q + 1'b1;
      ms_q <= !brk_busy ? '0 : ms_tick ? ms_q + 16'h0001 : ms_q;
      case (brk_q) // [R15]
        BK_HELD: if (DRV.brake_cmd) brk_q <= BK_REL_WAIT;
        BK_REL_WAIT:
          if (!DRV.brake_cmd)
            brk_q <= BK_HELD;
          else if (rel_done)
            brk_q <= BK_RELEASED;
        BK_RELEASED: if (!DRV.brake_cmd) brk_q <= BK_HOLD_WAIT;
        BK_HOLD_WAIT:
          if (DRV.brake_cmd)
            brk_q <= BK_RELEASED;
          else if (hold_done)
            brk_q <= BK_HELD;
        default: brk_q <= BK_HELD;
      endcase
    end
  end

  // ========================================================================
  // Output functions, index is the output function code
  wire fault = DRV.alm_general; // [R14]
  logic [FN_DO_MAX:1] fn_d, fn_q;
  assign fn_d[1] = DRV.ctrl_pwr && DRV.main_pwr && !fault; // [R8]
  assign fn_d[2] = DRV.servo_en && !fault; // [R9]
  assign fn_d[3] = mag(SPEED) < zero_thr_q; // [R10]
  assign fn_d[4] = mag(SPEED) > target_thr_q; // [R11]
  assign fn_d[5] = is_pt && mag(POS_ERR) < pos_win_q; // [R12]
  assign fn_d[6] = DRV.torque_limit && !is_tq; // [R13]
  assign fn_d[7] = fault; // [R14]
  assign fn_d[8] = brk_q == BK_RELEASED || brk_q == BK_HOLD_WAIT; // [R15]

  logic [N_DO-1:0] do_d;
  always_comb
  begin
    for (int i = 0; i < N_DO; i++)
    begin
      do_d[i] = 1'b0;
      for (int c = 1; c <= FN_DO_MAX; c++)
        if (do_map_q[i*8 +: 8] == 8'(c))
          do_d[i] = fn_q[c];
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fn_q <= '0;
      DO_PIN <= '0;
    end
    else
    begin
      fn_q <= fn_d; // [R16]
      DO_PIN <= do_d;
    end
  end

  // ========================================================================
  // Interrupts: fault rise, ready loss, in-position reached, brake change
  assign int_ev = {fn_d[8] ^ fn_q[8], fn_d[5] & ~fn_q[5], ~fn_d[1] & fn_q[1],
                   fn_d[7] & ~fn_q[7]};

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      int_stat_q <= '0;
    else
      int_stat_q <= (int_stat_q & ~int_clr) | int_ev; // Set wins over clear
  end

  assign IRQ = |(int_stat_q & int_mask_q);

  // ========================================================================
  // Read back
  logic [31:0] rd_mux;
  always_comb
  begin
    case (ADDR)
      OFS_DI_MAP_LO: rd_mux = di_map_q[31:0];
      OFS_DI_MAP_HI: rd_mux = di_map_q[63:32];
      OFS_DO_MAP: rd_mux = do_map_q;
      OFS_MODE: rd_mux = {24'h000000, mode_q};
      OFS_ZERO_THR: rd_mux = {16'h0000, zero_thr_q};
      OFS_TARGET_THR: rd_mux = {16'h0000, target_thr_q};
      OFS_POS_WIN: rd_mux = {16'h0000, pos_win_q};
      OFS_GEAR_NUM1: rd_mux = gear_q[0];
      OFS_GEAR_NUM1 + 8'h04: rd_mux = gear_q[1];
      OFS_GEAR_NUM1 + 8'h08: rd_mux = gear_q[2];
      OFS_GEAR_NUM1 + 8'h0c: rd_mux = gear_q[3];
      OFS_GEAR_DEN: rd_mux = gear_den_q;
      OFS_TQ_CFG: rd_mux = {31'h00000000, tq_cfg_q};
      OFS_BRK_ON: rd_mux = {16'h0000, brk_on_q};
      OFS_BRK_OFF: rd_mux = {16'h0000, brk_off_q};
      OFS_LIVE: rd_mux = {5'h00, 3'(mode_eff), fn_q, 8'(DO_PIN), di_lvl};
      OFS_INT_STAT: rd_mux = {28'h0000000, int_stat_q};
      OFS_INT_MASK: rd_mux = {28'h0000000, int_mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_q <= '0;
    else
      rdata_q <= RD ? rd_mux : 32'h00000000;
  end

  assign RDATA = rdata_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  jog_fwd_a: assert property (in_jog_f && !in_jog_r |=> CMD.jog_fwd) // [R1]
    else $error("forward jog not issued");
  jog_rev_a: assert property (CMD.jog_rev |-> $past(in_jog_r) && !$past(in_jog_f)) // [R2]
    else $error("reverse jog without cause");
  gear_index_a: assert property (is_pt |=> CMD.gear_sel == $past({in_g1, in_g0})) // [R3]
    else $error("gear index mismatch");
  pulse_inhibit_a: assert property (in_inh |=> !CMD.pulse_en) // [R4]
    else $error("pulse command not inhibited");
  torque_src_a: assert property (!is_tq |=> CMD.tq_src == 2'b00 && !CMD.tq_neg) // [R5]
    else $error("torque source outside torque mode");
  dual_mode_a: assert property (mode_q == MODE_PT_T && in_t_pt |-> mode_eff == MD_PT) // [R6]
    else $error("dual mode switch wrong");
  ready_out_a: assert property (fn_q[1] |-> $past(DRV.ctrl_pwr && DRV.main_pwr) // [R8]
                                && !$past(DRV.alm_general))
    else $error("ready without power or with alarm");
  servo_on_a: assert property (DRV.alm_general |=> !fn_q[2]) // [R9]
    else $error("servo-on during alarm");
  zero_speed_a: assert property (mag(SPEED) < zero_thr_q |=> fn_q[3]) // [R10]
    else $error("zero speed missed");
  target_spd_a: assert property (fn_q[4] |-> $past(mag(SPEED)) > $past(target_thr_q)) // [R11]
    else $error("target speed wrongly set");
  in_pos_a: assert property (!is_pt |=> !fn_q[5]) // [R12]
    else $error("in-position outside position mode");
  torque_lim_a: assert property (is_tq |=> !fn_q[6]) // [R13]
    else $error("torque limit shown in torque mode");
  fault_excl_a: assert property (!DRV.alm_general |=> !fn_q[7]) // [R14]
    else $error("fault reports excluded alarm");
  brake_hold_a: assert property (brk_q == BK_HELD && !DRV.brake_cmd |=> !fn_q[8]) // [R15]
    else $error("brake released without command");
  int_set_a: assert property (int_ev[0] |=> int_stat_q[0]) // [R16]
    else $error("interrupt event lost");

  jog_cov_c: cover property (CMD.jog_fwd ##1 !CMD.jog_fwd);
  gear_cov_c: cover property (is_pt && CMD.gear_sel == 2'b11);
  brake_cov_c: cover property (brk_q == BK_REL_WAIT ##[1:5] brk_q == BK_RELEASED);
  irq_cov_c: cover property (IRQ);
endmodule

// ### tb/sdf_ctl_model.sv
`timescale 1ns/100ps
// ==========================================================
// Controller and drive-core stand-in
module sdf_ctl_model (
  // Clock
  input wire logic clk,
  // Levels toward the block
  output logic [7:0] di_pin,
  output sdf_pkg::sdf_drv_s drv,
  output logic [15:0] speed,
  output logic [15:0] pos_err
);
  import sdf_pkg::*;
  initial
  begin
    di_pin = 8'h00;
    drv = '0;
    speed = 16'h0000;
    pos_err = 16'h0000;
  end
  // Levels change just after an edge, then stand until the next call
  task automatic put(input logic [7:0] d, input sdf_drv_s v, input logic [15:0] s,
                     input logic [15:0] e);
    @(posedge clk);
    di_pin <= d;
    drv <= v;
    speed <= s;
    pos_err <= e;
  endtask
  // Random levels; brake request stays with the caller so its timing is known
  task automatic roll(input logic brk);
    sdf_drv_s v;
    v = sdf_drv_s'(9'($urandom));
    v.brake_cmd = brk;
    put(8'($urandom), v, 16'($urandom_range(100) - 50), 16'($urandom_range(100) - 50));
  endtask
endmodule

// ### tb/sdf_dio_map_test.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the pin function map
module sdf_dio_map_test;
  import sdf_pkg::*;
  localparam int ZT = 20;
  localparam int TT = 40;
  localparam int PW = 30;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [7:0] di;
  logic [3:0] do_pin;
  sdf_drv_s drv;
  logic [15:0] spd;
  logic [15:0] err;
  sdf_cmd_s cmd;
  logic [31:0] gnum;
  logic [31:0] gden;
  logic irq;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] mtab [9] = '{8'd11, 8'd12, 8'd13, 8'd14, 8'd15, 8'd16, 8'd18, 8'd19, 8'd20};
  sdf_mode_e etab [9] = '{MD_PT, MD_S, MD_T, MD_SZ, MD_TZ, MD_PT, MD_S, MD_S, MD_T};

  sdf_dio_map #(.N_DI(8), .N_DO(4), .MS_CYC(4)) sdf_dio_map_inst (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .DI_PIN(di), .DO_PIN(do_pin), .DRV(drv), .SPEED(spd),
    .POS_ERR(err), .CMD(cmd), .GEAR_NUM(gnum), .GEAR_DEN(gden), .IRQ(irq));
  sdf_ctl_model sdf_ctl_model_inst (
    .clk(clk), .di_pin(di), .drv(drv), .speed(spd), .pos_err(err));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ==========================================================
  // Checking and bus tasks
  task automatic stop_test;
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Edges until output pin 0 reaches a level, bounded
  task automatic wait_do(input logic lvl, output int n);
    n = 0;
    while (do_pin[0] !== lvl && n < 40)
    begin
      cyc(1);
      n++;
    end
  endtask

  // ==========================================================
  // Reference model
  function automatic logic [7:0] fnv(sdf_drv_s v, logic [15:0] s, logic [15:0] e, bit pt,
                                     bit tq);
    int sa;
    int ea;
    sa = $signed(s);
    ea = $signed(e);
    sa = sa < 0 ? -sa : sa;
    ea = ea < 0 ? -ea : ea;
    // Brake output held off while the request stays low
    return {1'b0, v.alm_general, v.torque_limit & !tq, 1'(pt && ea < PW), 1'(sa > TT),
            1'(sa < ZT), v.servo_en & ~v.alm_general,
            v.ctrl_pwr & v.main_pwr & ~v.alm_general};
  endfunction
  function automatic sdf_cmd_s cmdv(logic [7:0] d, bit pt, bit tq, bit cfg);
    sdf_cmd_s c;
    c = '0;
    c.jog_fwd = d[0] & ~d[1];
    c.jog_rev = d[1] & ~d[0];
    c.pulse_en = pt & ~d[4];
    c.gear_sel = pt ? {d[3], d[2]} : 2'b00;
    c.tq_src = (tq && !cfg) ? {d[6], d[5]} : 2'b00;
    c.tq_neg = tq & cfg & d[6] & ~d[5];
    c.mode = pt ? MD_PT : MD_T;
    return c;
  endfunction
  function automatic logic [3:0] do_exp(logic [31:0] map, logic [7:0] f);
    logic [3:0] r;
    logic [7:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = map[8*i +: 8];
      r[i] = (c >= 8'h01 && c <= 8'h08) ? f[c - 8'h01] : 1'b0;
    end
    return r;
  endfunction

  // ==========================================================
  // Scenarios
  initial
  begin
    sdf_drv_s v;
    logic [31:0] r;
    logic [31:0] map;
    logic [7:0] f;
    int n;
    bit ok;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    void'($urandom(13942));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(OFS_MODE, r); chk(r, 32'h0000_000b);
    rd_reg(OFS_ZERO_THR, r); chk(r, 32'h0000_000a);
    rd_reg(OFS_TARGET_THR, r); chk(r, 32'h0000_0bb8);
    rd_reg(OFS_POS_WIN, r); chk(r, 32'h0000_0064);
    wr_reg(8'h48, 32'hffff_ffff);
    rd_reg(8'h48, r); chk(r, 32'h0000_0000);
    wr_reg(OFS_ZERO_THR, 32'(ZT));
    wr_reg(OFS_TARGET_THR, 32'(TT));
    wr_reg(OFS_POS_WIN, 32'(PW));
    // Pin 7 left on code zero throughout the random phase
    wr_reg(OFS_DI_MAP_LO, 32'h4443_3837);
    wr_reg(OFS_DI_MAP_HI, 32'h0049_4845);
    wr_reg(OFS_GEAR_DEN, 32'h0000_0077);
    for (int k = 0; k < 4; k++)
      wr_reg(OFS_GEAR_NUM1 + 8'(4 * k), 32'h100 + k);
    cyc(2); chk(gden, 32'h0000_0077);
    for (int m = 0; m < 2; m++)
      for (int cfg = 0; cfg < 2; cfg++)
      begin
        wr_reg(OFS_MODE, m ? 32'(MODE_T) : 32'(MODE_PT));
        wr_reg(OFS_TQ_CFG, 32'(cfg));
        for (int k = 0; k < 16; k++)
        begin
          map = k[0] ? 32'h0907_0605 : 32'h0403_0201;
          wr_reg(OFS_DO_MAP, map);
          sdf_ctl_model_inst.roll(1'b0);
          cyc(7);
          chk(32'(cmd), 32'(cmdv(di, m == 0, m == 1, cfg[0])));
          chk(gnum, (m == 0) ? 32'h100 + {di[3], di[2]} : 32'h100);
          f = fnv(drv, spd, err, m == 0, m == 1);
          chk(32'(do_pin), 32'(do_exp(map, f)));
          rd_reg(OFS_LIVE, r); chk(r[23:16], f);
        end
      end
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(OFS_MODE, 32'(mtab[i]));
      cyc(4); chk(32'(cmd.mode), 32'(etab[i]));
    end
    // Dual modes with the switching input held on
    sdf_ctl_model_inst.put(8'h80, '0, 16'h0000, 16'h0100);
    for (int i = 6; i < 9; i++)
    begin
      // Switch codes are hex, so they do not follow the decimal mode values
      wr_reg(OFS_DI_MAP_HI, {(i == 6) ? FN_SEL_PT_S : (i == 7) ? FN_SEL_S_T : FN_SEL_T_PT,
                             24'h49_4845});
      wr_reg(OFS_MODE, 32'(mtab[i]));
      cyc(8); chk(32'(cmd.mode), (i == 7) ? 32'(MD_T) : 32'(MD_PT));
    end
    wr_reg(OFS_MODE, 32'(MODE_PT));
    v = '0;
    v.ctrl_pwr = 1'b1;
    v.main_pwr = 1'b1;
    sdf_ctl_model_inst.put(8'h00, v, 16'h0000, 16'h0100);
    cyc(8);
    wr_reg(OFS_INT_MASK, 32'h0);
    wr_reg(OFS_INT_STAT, 32'hf);
    rd_reg(OFS_INT_STAT, r); chk(r, 32'h0);
    v.alm_general = 1'b1;
    sdf_ctl_model_inst.put(8'h00, v, 16'h0000, 16'h0100);
    cyc(6);
    rd_reg(OFS_INT_STAT, r); chk(r, 32'h3);
    chk(32'(irq), 32'h0);
    wr_reg(OFS_INT_MASK, 32'h1);
    cyc(1); chk(32'(irq), 32'h1);
    wr_reg(OFS_INT_STAT, 32'h1);
    cyc(1); chk(32'(irq), 32'h0);
    rd_reg(OFS_INT_STAT, r); chk(r, 32'h2);
    // Brake: on delay 2 units of 4 cycles, off delay 1 unit
    v.alm_general = 1'b0;
    wr_reg(OFS_DO_MAP, 32'h0000_0008);
    wr_reg(OFS_BRK_ON, 32'h2);
    wr_reg(OFS_BRK_OFF, 32'h1);
    wr_reg(OFS_INT_STAT, 32'hf);
    v.brake_cmd = 1'b1;
    sdf_ctl_model_inst.put(8'h00, v, 16'h0000, 16'h0100);
    wait_do(1'b1, n);
    chk(32'(n >= 8 && n <= 14), 32'h1);
    v.brake_cmd = 1'b0;
    sdf_ctl_model_inst.put(8'h00, v, 16'h0000, 16'h0100);
    wait_do(1'b0, n);
    chk(32'(n >= 4 && n <= 10), 32'h1);
    v.brake_cmd = 1'b1;
    sdf_ctl_model_inst.put(8'h00, v, 16'h0000, 16'h0100);
    cyc(3);
    v.brake_cmd = 1'b0;
    sdf_ctl_model_inst.put(8'h00, v, 16'h0000, 16'h0100);
    ok = 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      cyc(1);
      ok &= (do_pin[0] === 1'b0);
    end
    chk(32'(ok), 32'h1);
    rd_reg(OFS_INT_STAT, r); chk(32'(r[3]), 32'h1);
    stop_test;
  end

  // Whole run needs about a thousand cycles
  initial
  begin
    #300000;
    miscompares++;
    stop_test;
  end
endmodule
